// ### hrc_pkg.sv
// shared constants and types for the hardware reset configuration sequencer
package hrc_pkg;

   // sequence lengths, in cycles of the clock each one counts
   localparam int unsigned CFG_CYCLES       = 1024;
   localparam int unsigned PLL_REF_CYCLES   = 800;
   localparam int unsigned HARD_HOLD_CYCLES = 512;
   localparam int unsigned SOFT_GAP_CYCLES  = 3;
   localparam int unsigned PREDIV_RATIO     = 1;
   localparam int unsigned BUS_DIV_RATIO    = 1;
   localparam int unsigned SEQ_CNT_W        = 11;
   localparam int unsigned DIV_CNT_W        = 8;

   // register map
   localparam int unsigned ADDR_W        = 12;
   localparam logic [11:0] ADDR_CFGWORD  = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [31:0] CFGWORD_RST   = 32'h0000_0000;

   // reset configuration word fields
   localparam int unsigned CMH_W          = 4;
   localparam int unsigned CFG_CMH_LSB    = 0;
   localparam int unsigned CFG_DLLBYP_BIT = 8;
   localparam logic [31:0] CFGWORD_MASK   = 32'h0000_010F;

   // status word fields
   localparam int unsigned ST_STATE_LSB   = 0;
   localparam int unsigned ST_HWMODE_BIT  = 4;
   localparam int unsigned ST_SLAVE_BIT   = 5;
   localparam int unsigned ST_DEBUG_BIT   = 6;
   localparam int unsigned ST_BOOT_LSB    = 7;
   localparam int unsigned ST_CMODE_LSB   = 9;
   localparam int unsigned ST_PLLLCK_BIT  = 12;
   localparam int unsigned ST_DLLLCK_BIT  = 13;
   localparam int unsigned ST_HARD_BIT    = 14;
   localparam int unsigned ST_SOFT_BIT    = 15;

   typedef enum logic [2:0] {
      HRC_IDLE,
      HRC_HOSTWAIT,
      HRC_CONFIG,
      HRC_PLL,
      HRC_DLL,
      HRC_HOLD,
      HRC_SOFT,
      HRC_RUN
   } hrc_state_e;

   typedef struct packed {
      logic       host_port_enable_strap;
      logic       config_role_strap;
      logic       debug_request_strap;
      logic [1:0] boot_mode_straps;
   } hrc_straps_s;

   localparam hrc_straps_s STRAPS_RST = '0;

endpackage : hrc_pkg

// ### hrc_cnt.sv
// loadable down counter, used for sequence timing and clock dividers
`timescale 1ns/100ps
`default_nettype none
module hrc_cnt #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         en,
   output logic              zero
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (en && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign zero = (cnt_q == '0);
endmodule : hrc_cnt
`default_nettype wire

// ### hrc_seq.sv
// power-on reset sequencer for hardware reset configuration, with apb registers
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module hrc_seq
   import hrc_pkg::*;
#(
   parameter int unsigned CFG_LEN  = CFG_CYCLES,
   parameter int unsigned PLL_LEN  = PLL_REF_CYCLES,
   parameter int unsigned HARD_LEN = HARD_HOLD_CYCLES,
   parameter int unsigned SOFT_LEN = SOFT_GAP_CYCLES,
   parameter int unsigned PREDIV   = PREDIV_RATIO,
   parameter int unsigned BUS_DIV  = BUS_DIV_RATIO
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              power_on_reset_n,
   input  wire hrc_straps_s       straps,
   input  wire logic [2:0]        clock_mode_straps,
   input  wire logic              dll_lock_in,
   output logic                   hard_reset_n,
   output logic                   soft_reset_n,
   output logic                   clocks_enable,
   output logic                   dll_enable,
   output logic [CMH_W+2:0]       pll_setting,
   output logic                   hw_config_mode,
   output logic                   config_slave,
   output hrc_straps_s            straps_latched
);

   hrc_state_e            state_q;
   hrc_state_e            state_d;
   logic                  por_q;
   logic                  por_rise;
   logic [31:0]           cfg_q;
   logic                  dll_bypass;
   logic [CMH_W-1:0]      cmh_field;
   logic [2:0]            cmode_q;
   logic                  pll_locked_q;
   logic                  seq_load;
   logic [SEQ_CNT_W-1:0]  seq_val;
   logic                  seq_en;
   logic                  seq_zero;
   logic                  ref_en;
   logic                  bus_en;
   logic [31:0]           status;
   logic                  apb_wr;

   assign dll_bypass = cfg_q[CFG_DLLBYP_BIT];
   assign cmh_field  = cfg_q[CFG_CMH_LSB +: CMH_W];
   assign por_rise   = power_on_reset_n & ~por_q;

   // reference clock enable after the pll pre-divider, and bus clock enable
   hrc_cnt #(.W(DIV_CNT_W)) u_ref_div (
      .clk      (pclk),
      .rst_n    (presetn),
      .load     (ref_en),
      .load_val (DIV_CNT_W'(PREDIV - 1)),
      .en       (1'b1),
      .zero     (ref_en)
   );

   hrc_cnt #(.W(DIV_CNT_W)) u_bus_div (
      .clk      (pclk),
      .rst_n    (presetn),
      .load     (bus_en),
      .load_val (DIV_CNT_W'(BUS_DIV - 1)),
      .en       (1'b1),
      .zero     (bus_en)
   );

   hrc_cnt #(.W(SEQ_CNT_W)) u_seq_cnt (
      .clk      (pclk),
      .rst_n    (presetn),
      .load     (seq_load),
      .load_val (seq_val),
      .en       (seq_en),
      .zero     (seq_zero)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_q <= 1'b0;
      end else begin
         por_q <= power_on_reset_n;
      end
   end

   // sequence state machine
   always_comb begin
      state_d = state_q;
      if (!power_on_reset_n) begin
         state_d = HRC_IDLE;
      end else begin
         case (state_q)
            HRC_IDLE: begin
               if (por_rise) begin
                  if (!straps.host_port_enable_strap) begin
                     state_d = HRC_CONFIG;
                  end else begin
                     state_d = HRC_HOSTWAIT;
                  end
               end
            end
            HRC_HOSTWAIT: state_d = HRC_HOSTWAIT;
            HRC_CONFIG: begin
               if (seq_zero) begin
                  state_d = HRC_PLL;
               end
            end
            HRC_PLL: begin
               if (seq_zero) begin
                  state_d = dll_bypass ? HRC_HOLD : HRC_DLL;
               end
            end
            HRC_DLL: begin
               if (dll_lock_in) begin
                  state_d = HRC_HOLD;
               end
            end
            HRC_HOLD: begin
               if (seq_zero) begin
                  state_d = HRC_SOFT;
               end
            end
            HRC_SOFT: begin
               if (seq_zero) begin
                  state_d = HRC_RUN;
               end
            end
            default: state_d = HRC_RUN;
         endcase
      end
   end

   // counter reloads on every state change with the new phase length
   always_comb begin
      seq_load = (state_d != state_q);
      seq_val  = '0;
      seq_en   = 1'b0;
      case (state_d)
         HRC_CONFIG: seq_val = SEQ_CNT_W'(CFG_LEN - 1);
         HRC_PLL:    seq_val = SEQ_CNT_W'(PLL_LEN - 1);
         HRC_HOLD:   seq_val = SEQ_CNT_W'(HARD_LEN - 1);
         HRC_SOFT:   seq_val = SEQ_CNT_W'(SOFT_LEN - 1);
         default:    seq_val = '0;
      endcase
      case (state_q)
         HRC_CONFIG:          seq_en = 1'b1;
         HRC_PLL:             seq_en = ref_en;
         HRC_HOLD, HRC_SOFT:  seq_en = bus_en;
         default:             seq_en = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= HRC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // strap capture, once per power-on release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         straps_latched <= STRAPS_RST;
         hw_config_mode <= 1'b0;
         config_slave   <= 1'b0;
      end else if (por_rise && state_q == HRC_IDLE) begin
         straps_latched <= straps;
         hw_config_mode <= ~straps.host_port_enable_strap;
         config_slave   <= straps.config_role_strap;
      end
   end

   // clock mode sampling and pll setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmode_q     <= '0;
         pll_setting <= '0;
      end else if (state_q == HRC_CONFIG && state_d == HRC_PLL) begin
         cmode_q     <= clock_mode_straps;
         pll_setting <= {cmh_field, clock_mode_straps};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_locked_q <= 1'b0;
      end else if (!power_on_reset_n || state_d == HRC_IDLE) begin
         pll_locked_q <= 1'b0;
      end else if (state_q == HRC_PLL && seq_zero) begin
         pll_locked_q <= 1'b1;
      end
   end

   // reset and clock outputs follow the next state so they align with state_q
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hard_reset_n  <= 1'b0;
         soft_reset_n  <= 1'b0;
         clocks_enable <= 1'b0;
         dll_enable    <= 1'b0;
      end else begin
         hard_reset_n  <= (state_d == HRC_SOFT) || (state_d == HRC_RUN);
         soft_reset_n  <= (state_d == HRC_RUN);
         clocks_enable <= (state_d >= HRC_DLL);
         dll_enable    <= (state_d >= HRC_DLL) && !dll_bypass;
      end
   end

   // apb slave: one wait-free access phase, pready raised from the setup cycle
   assign apb_wr = psel && penable && pwrite && pready;

   always_comb begin
      status = '0;
      status[ST_STATE_LSB +: 3]  = state_q;
      status[ST_HWMODE_BIT]      = hw_config_mode;
      status[ST_SLAVE_BIT]       = config_slave;
      status[ST_DEBUG_BIT]       = straps_latched.debug_request_strap;
      status[ST_BOOT_LSB +: 2]   = straps_latched.boot_mode_straps;
      status[ST_CMODE_LSB +: 3]  = cmode_q;
      status[ST_PLLLCK_BIT]      = pll_locked_q;
      status[ST_DLLLCK_BIT]      = dll_enable && dll_lock_in;
      status[ST_HARD_BIT]        = hard_reset_n;
      status[ST_SOFT_BIT]        = soft_reset_n;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            if (paddr == ADDR_CFGWORD) begin
               prdata  <= cfg_q;
               pslverr <= 1'b0;
            end else if (paddr == ADDR_STATUS) begin
               prdata  <= status;
               pslverr <= 1'b0;
            end else begin
               prdata  <= '0;
               pslverr <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= CFGWORD_RST;
      end else if (apb_wr && paddr == ADDR_CFGWORD) begin
         cfg_q <= pwdata & CFGWORD_MASK;
      end
   end

   // checks
   localparam int CFG_LAST = CFG_CYCLES - 1;
   logic [SEQ_CNT_W-1:0] cfg_len_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_len_q <= '0;
      end else if (state_q != HRC_CONFIG) begin
         cfg_len_q <= '0;
      end else begin
         cfg_len_q <= cfg_len_q + SEQ_CNT_W'(1);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   resets_held_a: assert property ((state_q != HRC_SOFT && state_q != HRC_RUN)
      |-> !hard_reset_n && !soft_reset_n) else $error("reset released early");
   por_abort_a: assert property (!power_on_reset_n
      |=> state_q == HRC_IDLE && !hard_reset_n && !soft_reset_n)
      else $error("power-on reset did not restart");
   role_capture_a: assert property ((por_rise && state_q == HRC_IDLE)
      |=> config_slave == $past(straps.config_role_strap)
          && hw_config_mode == !$past(straps.host_port_enable_strap))
      else $error("role or mode strap wrong");
   strap_hold_a: assert property (!(por_rise && state_q == HRC_IDLE)
      |=> $stable(straps_latched)) else $error("straps changed");
   cfg_length_a: assert property ((CFG_LEN == CFG_CYCLES && state_q == HRC_CONFIG
      && state_d == HRC_PLL) |-> cfg_len_q == SEQ_CNT_W'(CFG_LAST))
      else $error("configuration period wrong");
   pll_gate_a: assert property ((state_q == HRC_PLL) |-> !clocks_enable && !pll_locked_q)
      else $error("clocks before pll lock");
   pll_setting_a: assert property ((state_q == HRC_CONFIG && state_d == HRC_PLL)
      |=> pll_setting == {$past(cmh_field), $past(clock_mode_straps)})
      else $error("pll setting wrong");
   dll_path_a: assert property ((state_q == HRC_PLL && state_d == HRC_HOLD) |-> dll_bypass)
      else $error("dll lock skipped");
   soft_gap_a: assert property ((BUS_DIV == 1 && SOFT_LEN == 3 && $rose(hard_reset_n)
      && power_on_reset_n) ##1 power_on_reset_n [*3]
      |-> soft_reset_n && !$past(soft_reset_n))
      else $error("soft reset gap wrong");

endmodule : hrc_seq
`default_nettype wire

// ### hrc_board.sv
// board side model: power-on reset source, strap drivers and dll lock
`timescale 1ns/100ps
`default_nettype none
module hrc_board
   import hrc_pkg::*;
(
   input  wire logic   pclk,
   input  wire logic   clocks_enable,
   input  wire logic   dll_enable,
   output logic        power_on_reset_n,
   output hrc_straps_s straps,
   output logic [2:0]  clock_mode_straps,
   output logic        dll_lock_in
);
   int lock_wait = 4;
   int lock_cnt  = 0;
   initial begin
      power_on_reset_n = 1'b0;
      straps = STRAPS_RST;
      clock_mode_straps = 3'h0;
      dll_lock_in = 1'b0;
   end
   // dll reports lock a chosen number of cycles after it is enabled
   always @(posedge pclk) begin
      lock_cnt <= dll_enable ? lock_cnt + 1 : 0;
      dll_lock_in <= dll_enable && (lock_cnt >= lock_wait);
   end
   // mode pins serve other uses once clocks run, so they keep changing
   always @(posedge pclk) begin
      if (clocks_enable) clock_mode_straps <= ~clock_mode_straps;
   end
   task automatic power_cycle(input hrc_straps_s s, input logic [2:0] cm, input int lw);
      power_on_reset_n <= 1'b0;
      lock_wait = lw;
      repeat (16) @(posedge pclk);
      straps <= s;
      clock_mode_straps <= cm;
      @(posedge pclk) power_on_reset_n <= 1'b1;
      repeat (2) @(posedge pclk);
      straps <= hrc_straps_s'(~s);
   endtask : power_cycle
   task automatic drop;
      power_on_reset_n <= 1'b0;
   endtask : drop
endmodule : hrc_board
`default_nettype wire

// ### hrc_seq_bench.sv
// self-checking bench for the reset configuration sequencer
`timescale 1ns/100ps
`default_nettype none
module hrc_seq_bench
   import hrc_pkg::*;
;
   localparam int PLL_N = 6;
   localparam int HOLD_N = 5;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, w;
   logic pready, pslverr, er, power_on_reset_n, dll_lock_in, hard_reset_n, soft_reset_n;
   logic clocks_enable, dll_enable, hw_config_mode, config_slave, hi;
   logic [2:0] clock_mode_straps;
   logic [CMH_W+2:0] pll_setting;
   hrc_straps_s straps, straps_latched, s;
   int mismatches = 0, tests_run = 0, n;
   always #12.5 pclk = ~pclk;
   hrc_seq #(.PLL_LEN(PLL_N), .HARD_LEN(HOLD_N)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on_reset_n, .straps,
      .clock_mode_straps, .dll_lock_in, .hard_reset_n, .soft_reset_n, .clocks_enable,
      .dll_enable, .pll_setting, .hw_config_mode, .config_slave, .straps_latched);
   hrc_board board (.pclk, .clocks_enable, .dll_enable, .power_on_reset_n, .straps,
      .clock_mode_straps, .dll_lock_in);
   task automatic conclude;
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         conclude();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // status word expected once a hardware-mode sequence has reached run
   function automatic logic [31:0] exp_status(input logic byp, input hrc_straps_s st,
                                              input logic [2:0] cm);
      logic [31:0] v;
      v = '0;
      v[ST_STATE_LSB +: 3] = HRC_RUN;
      v[ST_HWMODE_BIT]     = 1'b1;
      v[ST_SLAVE_BIT]      = st.config_role_strap;
      v[ST_DEBUG_BIT]      = st.debug_request_strap;
      v[ST_BOOT_LSB +: 2]  = st.boot_mode_straps;
      v[ST_CMODE_LSB +: 3] = cm;
      v[ST_PLLLCK_BIT]     = 1'b1;
      v[ST_DLLLCK_BIT]     = !byp;
      v[ST_HARD_BIT]       = 1'b1;
      v[ST_SOFT_BIT]       = 1'b1;
      return v;
   endfunction : exp_status
   // one full power-on sequence with random straps and mode pins
   task automatic run_seq(input logic byp, input logic role, input int lw);
      logic [2:0] cm;
      logic [3:0] cmh;
      logic de;
      int ce, lo, g;
      s = hrc_straps_s'(5'($urandom));
      s.host_port_enable_strap = 1'b0;
      s.config_role_strap = role;
      cm = 3'($urandom);
      cmh = 4'($urandom);
      apb(1'b1, ADDR_CFGWORD, {23'h0, byp, 4'h0, cmh});
      board.power_cycle(s, cm, lw);
      n = 0;
      ce = 0;
      de = 1'b0;
      hi = 1'b0;
      while (hard_reset_n !== 1'b1 && n < 4000) begin
         @(posedge pclk);
         n++;
         if (clocks_enable === 1'b1 && ce == 0) ce = n;
         if (dll_enable === 1'b1) de = 1'b1;
         if (soft_reset_n !== 1'b0) hi = 1'b1;
      end
      if (n >= 4000) begin
         mismatches++;
         conclude();
      end
      lo = CFG_CYCLES + PLL_N + HOLD_N + (byp ? 0 : lw);
      chk(n + 4 >= lo && n <= lo + 8, 1);
      chk(ce + 4 >= CFG_CYCLES + PLL_N && ce < n, 1);
      chk(de, !byp);
      chk(hi, 0);
      for (g = 0; soft_reset_n !== 1'b1 && g < 10; g++) @(posedge pclk);
      chk(g, SOFT_GAP_CYCLES);
      chk(straps_latched, s);
      chk(config_slave, role);
      chk(hw_config_mode, 1);
      chk(pll_setting, {cmh, cm});
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd, exp_status(byp, s, cm));
      $display("sequence done, bypass %0d role %0d", byp, role);
   endtask : run_seq
   initial begin
      n = $urandom(5);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CFGWORD, 0);
      chk(rd, CFGWORD_RST);
      chk(er, 0);
      w = $urandom;
      apb(1'b1, ADDR_CFGWORD, w);
      apb(1'b1, ADDR_STATUS, '1);
      apb(1'b0, ADDR_CFGWORD, 0);
      chk(rd, w & CFGWORD_MASK);
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd, 0);
      apb(1'b0, 12'h008, 0);
      chk(er, 1);
      chk(rd, 0);
      $display("register test done");
      for (int i = 0; i < 4; i++) run_seq(i[0], i[1], 3 + $urandom_range(20));
      board.drop();
      repeat (3) @(posedge pclk);
      chk({hard_reset_n, soft_reset_n}, 0);
      board.power_cycle(s, 3'h5, 4);
      repeat (300) @(posedge pclk);
      board.drop();
      repeat (3) @(posedge pclk);
      chk({hard_reset_n, soft_reset_n}, 0);
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd[2:0], HRC_IDLE);
      $display("abort test done");
      s.host_port_enable_strap = 1'b1;
      board.power_cycle(s, 3'h2, 4);
      hi = 1'b0;
      repeat (CFG_CYCLES + PLL_N + HOLD_N + 40) begin
         @(posedge pclk);
         if (hard_reset_n !== 1'b0) hi = 1'b1;
      end
      chk(hi, 0);
      chk(hw_config_mode, 0);
      $display("host port strap test done");
      conclude();
   end
endmodule : hrc_seq_bench
`default_nettype wire
